// [logic/pat_pkg.sv]
// Purpose: Shared constants and carrier types for the approach / trigger timer block
// Assumes: 8-bit register port, one clock at 125 MHz
// Notes:   Register indices are byte addresses on the plain register port
package pat_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_CNT_STEP   = 4'h0;
    localparam logic [3:0] ADDR_ADJUST     = 4'h1;
    localparam logic [3:0] ADDR_TMR_CTRL   = 4'h2;
    localparam logic [3:0] ADDR_PRELOAD1   = 4'h3;
    localparam logic [3:0] ADDR_PRELOAD2   = 4'h4;
    localparam logic [3:0] ADDR_PRELOAD3   = 4'h5;
    localparam logic [3:0] ADDR_TMR_COUNT  = 4'h6;
    localparam logic [3:0] ADDR_RT_PERIOD  = 4'h7;
    localparam logic [3:0] ADDR_RT_TIMES   = 4'h8;
    localparam logic [3:0] ADDR_SEC_COUNT  = 4'h9;
    localparam logic [3:0] ADDR_SEC_CTRL   = 4'ha;
    localparam logic [3:0] ADDR_MODE       = 4'hb;
    localparam logic [3:0] ADDR_SEC_WIDTH  = 4'hc;
    localparam logic [3:0] ADDR_SEC_END    = 4'hd;
    localparam logic [3:0] ADDR_SEC_INCR   = 4'he;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CNT_LSB      = 3;
    localparam int STEP_LSB     = 0;
    localparam int HWSRC_BIT    = 7;
    localparam int REPEAT_LSB   = 4;
    localparam int CADJ_LSB     = 2;
    localparam int SADJ_LSB     = 0;
    localparam int RUN_BIT      = 4;
    localparam int EDGE_BIT     = 3;
    localparam int PSC_LSB      = 0;
    localparam int RTON_BIT     = 7;
    localparam int SECON_BIT    = 7;
    localparam int MODE_BIT     = 0;
    localparam int LOCK_BIT     = 1;
    localparam int PHASE_LSB    = 2;
    localparam logic [7:0] RESET_VAL = 8'h00;
    // ----------------------------------------------------------------
    // Codes
    // ----------------------------------------------------------------
    localparam logic [1:0] ADJ_INC = 2'h2;
    localparam logic [1:0] ADJ_DEC = 2'h3;
    localparam logic [1:0] PH_T1T2 = 2'h1;
    localparam logic [1:0] PH_T2T3 = 2'h2;
    localparam logic [1:0] CNT_MIN = 2'h0;
    localparam logic [1:0] CNT_MAX = 2'h3;
    localparam logic [9:0] PSC_BASE = 10'h07f;
    localparam int         RT_UNIT = 8;
    typedef enum logic [1:0] {
        PAT_SEC_OFF   = 2'b00,
        PAT_SEC_COPY  = 2'b01,
        PAT_SEC_FIXED = 2'b10,
        PAT_SEC_GROW  = 2'b11
    } pat_sec_mode_t;
    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pat_bus_t;
endpackage

// [logic/pat_ctrl.sv]
// Purpose: Approach sequencing, trigger timer, software re-trigger, secondary pulse
// Assumes: Single clock sys_clk; high-speed clock equals sys_clk; overvoltage pin passes two flops
// Notes:   Notes on behaviour follow
// Notes on behaviour
// - Trigger-count code 00..11 means one to four triggers.
// - Approach-step code 000..111 means step one to eight.
// - Approach-repeat code 000..111 means one to eight change steps.
// - Count adjust 00/01 hold, 10 increment, 11 decrement at each step.
// - Trigger-count stuck at 00 or 11 never moves on a change step; a software write still loads it.
// - Hardware mode: count adjust direction flips between t1-t2 and t2-t3.
// - Step adjust 00/01 hold, 10 increment, 11 decrement at each step.
// - Step field saturates at 111 and 000.
// - Hardware mode: step adjust direction flips between t1-t2 and t2-t3.
// - Run bit starts timer; writes ignored in hardware mode with overvoltage source.
// - Edge bit 0 picks rising, 1 picks falling overvoltage edge.
// - Timer ticks at fast clock over 128, 256, 512 or 1024.
// - Three 8-bit read-write preload registers, reset to zero.
// - Current timer count is readable, resets to zero.
// - Re-trigger count reached clears enable and raises interrupt.
// - Re-triggers spaced by (setting+1)*8 clocks; setting never zero (a zero setting is accepted and gives 8 clocks).
// - Seven-bit re-trigger count register, top bit reads zero.
// - Secondary width counter idle and zero in modes 00 and 01.
// - Secondary output low while secondary enable is zero.
// - Modes: 00 zero, 01 copy, 10 fixed width, 11 growing width.
// - Secondary pulse starts only with enabled main pulse.
// - Hardware source bit: 0 overvoltage edge, 1 run bit rising.
// - Mode bit 0-to-1 clears run bit and reloads timer from first preload.
// - Lock flag blocks software writes to count and step, and strobe updates of target.
`timescale 1ns/10ps
module pat_ctrl (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // Register port
    input  wire pat_pkg::pat_bus_t bus,
    output logic [7:0]            rdata,
    // Main pulse generator and pins
    input  wire logic             main_pulse_gen_on,
    input  wire logic             main_pulse,
    input  wire logic             overvoltage_event,
    input  wire logic             register_lock_flag,
    input  wire logic [1:0]       approach_phase,
    input  wire logic             approach_step_strobe,
    // Outputs
    output logic                  secondary_pulse,
    output logic                  retrigger_pulse,
    output logic                  retrigger_irq,
    output logic                  timer_trigger,
    output logic [2:0]            trigger_count_val,
    output logic [3:0]            approach_step_val,
    output logic [3:0]            approach_repeat_val,
    output logic [7:0]            approach_target
);
    typedef struct packed {
        logic [7:0] target;
        logic [1:0] cnt;
        logic [2:0] step;
        logic       hwsrc;
        logic [6:0] adj;
        logic [4:0] tmc;
        logic [7:0] pre1, pre2, pre3;
        logic [7:0] tmr;
        logic [9:0] psc;
        logic [7:0] rt;
        logic [6:0] rtn;
        logic [6:0] rtdone;
        logic [9:0] rtdiv;
        logic [7:0] sec_ctrl;
        logic [7:0] sec_w, sec_e, sec_i, sec_cur, sec_cnt;
        logic       sec_out;
        logic       mode;
        logic [1:0] ov_s;
        logic       ov_prev;
        logic       mp_prev;
        logic [7:0] rdata;
        logic       rt_pulse, irq, trig;
        logic [2:0] cnt_v;
        logic [3:0] step_v, rep_v;
    } pat_st_t;
    pat_st_t st, next_st;
    logic       hw_mode, ov_rise, ov_fall, ov_hit, tick, run_rise, step_up, step_dn, cnt_up, cnt_dn;
    logic       write_run, mp_rise;
    logic [9:0] psc_lim;
    // Adjust direction, reversed in the t2-t3 window of hardware mode
    function automatic logic [1:0] adj_dir(input logic [1:0] code, input logic hw, input logic [1:0] ph);
        logic [1:0] d;
        d = 2'b00;
        if (code == pat_pkg::ADJ_INC)
            d = 2'b01;
        else if (code == pat_pkg::ADJ_DEC)
            d = 2'b10;
        if (hw && ph == pat_pkg::PH_T2T3)
            d = {d[0], d[1]};
        else if (hw && ph != pat_pkg::PH_T1T2)
            d = 2'b00;
        return d;
    endfunction
    // ----------------------------------------------------------------
    // Decoded values and events
    // ----------------------------------------------------------------
    assign hw_mode = st.mode;
    assign ov_rise = st.ov_s[1] && !st.ov_prev;
    assign ov_fall = !st.ov_s[1] && st.ov_prev;
    assign ov_hit  = st.tmc[pat_pkg::EDGE_BIT] ? ov_fall : ov_rise;
    // Limit is (128 << code) - 1; the top code wraps through zero in ten bits on purpose
    assign psc_lim = ((pat_pkg::PSC_BASE + 10'h001) << st.tmc[pat_pkg::PSC_LSB +: 2]) - 10'h001;
    assign tick    = (st.psc == psc_lim);
    assign mp_rise = main_pulse && !st.mp_prev;
    assign write_run = bus.wr && bus.addr == pat_pkg::ADDR_TMR_CTRL;
    assign run_rise  = write_run && bus.wdata[pat_pkg::RUN_BIT] && !st.tmc[pat_pkg::RUN_BIT];
    assign {cnt_dn, cnt_up} = adj_dir(st.adj[pat_pkg::CADJ_LSB +: 2], hw_mode, approach_phase);
    assign {step_dn, step_up} = adj_dir(st.adj[pat_pkg::SADJ_LSB +: 2], hw_mode, approach_phase);
    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.ov_s    = {st.ov_s[0], overvoltage_event};
        next_st.ov_prev = st.ov_s[1];
        next_st.mp_prev = main_pulse;
        next_st.rt_pulse = 1'b0;
        next_st.irq      = 1'b0;
        next_st.trig     = 1'b0;
        // Prescaler and timer count
        // Evaluated first so that a reload further down wins over a tick in the same cycle
        if (st.tmc[pat_pkg::RUN_BIT]) begin
            next_st.psc = tick ? 10'h000 : st.psc + 10'h001;
            if (tick)
                next_st.tmr = st.tmr + 8'h01;
        end else begin
            next_st.psc = 10'h000;
        end
        // Software writes
        if (bus.wr) begin
            unique case (bus.addr)
                pat_pkg::ADDR_CNT_STEP: begin
                    if (!register_lock_flag) begin
                        next_st.cnt  = bus.wdata[pat_pkg::CNT_LSB +: 2];
                        next_st.step = bus.wdata[pat_pkg::STEP_LSB +: 3];
                    end
                    next_st.hwsrc = bus.wdata[pat_pkg::HWSRC_BIT];
                end
                pat_pkg::ADDR_ADJUST:   next_st.adj = bus.wdata[6:0];
                pat_pkg::ADDR_TMR_CTRL: begin
                    next_st.tmc[3:0] = bus.wdata[3:0];
                    if (!(hw_mode && !st.hwsrc))
                        next_st.tmc[pat_pkg::RUN_BIT] = bus.wdata[pat_pkg::RUN_BIT];
                end
                pat_pkg::ADDR_PRELOAD1:  next_st.pre1 = bus.wdata;
                pat_pkg::ADDR_PRELOAD2:  next_st.pre2 = bus.wdata;
                pat_pkg::ADDR_PRELOAD3:  next_st.pre3 = bus.wdata;
                pat_pkg::ADDR_RT_PERIOD: begin
                    next_st.rt = bus.wdata;
                    next_st.rtdone = 7'h00;
                    next_st.rtdiv  = 10'h000;
                end
                pat_pkg::ADDR_RT_TIMES:  next_st.rtn = bus.wdata[6:0];
                pat_pkg::ADDR_SEC_CTRL:  next_st.sec_ctrl = {bus.wdata[pat_pkg::SECON_BIT], 5'h00, bus.wdata[1:0]};
                pat_pkg::ADDR_MODE: begin
                    next_st.mode = bus.wdata[pat_pkg::MODE_BIT];
                    if (!register_lock_flag && bus.wdata[pat_pkg::LOCK_BIT])
                        next_st.target = next_st.target;
                    if (bus.wdata[pat_pkg::MODE_BIT] && !st.mode) begin
                        next_st.tmc[pat_pkg::RUN_BIT] = 1'b0;
                        next_st.tmr = st.pre1;
                    end
                end
                pat_pkg::ADDR_SEC_WIDTH: next_st.sec_w = bus.wdata;
                pat_pkg::ADDR_SEC_END:   next_st.sec_e = bus.wdata;
                pat_pkg::ADDR_SEC_INCR:  next_st.sec_i = bus.wdata;
                default: ;
            endcase
        end
        // Approach change steps from the sequencer
        if (approach_step_strobe) begin
            if (cnt_up && st.cnt != pat_pkg::CNT_MIN && st.cnt != pat_pkg::CNT_MAX)
                next_st.cnt = st.cnt + 2'h1;
            else if (cnt_dn && st.cnt != pat_pkg::CNT_MIN && st.cnt != pat_pkg::CNT_MAX)
                next_st.cnt = st.cnt - 2'h1;
            if (step_up && st.step != 3'h7)
                next_st.step = st.step + 3'h1;
            else if (step_dn && st.step != 3'h0)
                next_st.step = st.step - 3'h1;
            if (!register_lock_flag)
                next_st.target = st.target + {5'h00, st.step} + 8'h01;
        end
        // Timer trigger: overvoltage edge or run-bit rise in hardware mode, run-bit rise alone in software mode
        if (hw_mode && ((!st.hwsrc && ov_hit) || (st.hwsrc && run_rise))) begin
            next_st.tmc[pat_pkg::RUN_BIT] = 1'b1;
            next_st.tmr  = st.pre1;
            next_st.trig = 1'b1;
        end else if (!hw_mode && run_rise) begin
            next_st.trig = 1'b1;
        end
        // Software re-trigger period and count
        if (st.rt[pat_pkg::RTON_BIT]) begin
            if (st.rtdiv == {st.rt[6:0], 3'h7}) begin
                next_st.rtdiv    = 10'h000;
                next_st.rt_pulse = 1'b1;
                next_st.rtdone   = st.rtdone + 7'h01;
                if (st.rtdone + 7'h01 >= st.rtn) begin
                    next_st.rt[pat_pkg::RTON_BIT] = 1'b0;
                    next_st.irq = 1'b1;
                end
            end else begin
                next_st.rtdiv = st.rtdiv + 10'h001;
            end
        end
        // Secondary pulse
        if (!st.sec_ctrl[pat_pkg::SECON_BIT] || !main_pulse_gen_on) begin
            next_st.sec_out = 1'b0;
            next_st.sec_cnt = 8'h00;
        end else begin
            unique case (pat_pkg::pat_sec_mode_t'(st.sec_ctrl[1:0]))
                pat_pkg::PAT_SEC_OFF: begin
                    next_st.sec_out = 1'b0;
                    next_st.sec_cnt = 8'h00;
                end
                pat_pkg::PAT_SEC_COPY: begin
                    next_st.sec_out = main_pulse;
                    next_st.sec_cnt = 8'h00;
                end
                default: begin
                    if (mp_rise) begin
                        next_st.sec_out = 1'b1;
                        next_st.sec_cnt = 8'h00;
                        if (st.sec_ctrl[1:0] == 2'b10)
                            next_st.sec_cur = st.sec_w;
                        else if (st.sec_cur < st.sec_e)
                            next_st.sec_cur = st.sec_cur + st.sec_i;
                    end else if (st.sec_out) begin
                        next_st.sec_cnt = st.sec_cnt + 8'h01;
                        if (st.sec_cnt + 8'h01 >= st.sec_cur)
                            next_st.sec_out = 1'b0;
                    end
                end
            endcase
        end
        // Decoded views, registered with the fields so the outputs come from flops
        next_st.cnt_v  = {1'b0, next_st.cnt} + 3'h1;
        next_st.step_v = {1'b0, next_st.step} + 4'h1;
        next_st.rep_v  = {1'b0, next_st.adj[pat_pkg::REPEAT_LSB +: 3]} + 4'h1;
        // Read data, one cycle after the strobe
        next_st.rdata = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                pat_pkg::ADDR_CNT_STEP:  next_st.rdata = {st.hwsrc, 2'b00, st.cnt, st.step};
                pat_pkg::ADDR_ADJUST:    next_st.rdata = {1'b0, st.adj};
                pat_pkg::ADDR_TMR_CTRL:  next_st.rdata = {3'b000, st.tmc[4:3], 1'b0, st.tmc[1:0]};
                pat_pkg::ADDR_PRELOAD1:  next_st.rdata = st.pre1;
                pat_pkg::ADDR_PRELOAD2:  next_st.rdata = st.pre2;
                pat_pkg::ADDR_PRELOAD3:  next_st.rdata = st.pre3;
                pat_pkg::ADDR_TMR_COUNT: next_st.rdata = st.tmr;
                pat_pkg::ADDR_RT_PERIOD: next_st.rdata = st.rt;
                pat_pkg::ADDR_RT_TIMES:  next_st.rdata = {1'b0, st.rtn};
                pat_pkg::ADDR_SEC_COUNT: next_st.rdata = st.sec_cnt;
                pat_pkg::ADDR_SEC_CTRL:  next_st.rdata = st.sec_ctrl;
                pat_pkg::ADDR_MODE:      next_st.rdata = {4'h0, approach_phase, register_lock_flag, st.mode};
                pat_pkg::ADDR_SEC_WIDTH: next_st.rdata = st.sec_w;
                pat_pkg::ADDR_SEC_END:   next_st.rdata = st.sec_e;
                pat_pkg::ADDR_SEC_INCR:  next_st.rdata = st.sec_i;
                default:                 next_st.rdata = 8'h00;
            endcase
        end
    end
    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            // Decoded views show the value of code zero out of reset
            st        <= '0;
            st.cnt_v  <= 3'h1;
            st.step_v <= 4'h1;
            st.rep_v  <= 4'h1;
        end else begin
            st <= next_st;
        end
    end
    // Outputs straight from flops
    assign rdata               = st.rdata;
    assign secondary_pulse     = st.sec_out;
    assign retrigger_pulse     = st.rt_pulse;
    assign retrigger_irq       = st.irq;
    assign timer_trigger       = st.trig;
    assign trigger_count_val   = st.cnt_v;
    assign approach_step_val   = st.step_v;
    assign approach_repeat_val = st.rep_v;
    assign approach_target     = st.target;
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_lock_holds;
        @(posedge sys_clk) disable iff (!resetn)
        (register_lock_flag && !approach_step_strobe) |=> (st.cnt == $past(st.cnt));
    endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("Locked count changed");
    property p_sec_off;
        @(posedge sys_clk) disable iff (!resetn)
        !st.sec_ctrl[pat_pkg::SECON_BIT] |=> !secondary_pulse;
    endproperty
    a_sec_off: assert property (p_sec_off) else $error("Secondary pulse while off");
    property p_step_sat;
        @(posedge sys_clk) disable iff (!resetn)
        (st.step == 3'h7 && step_up && approach_step_strobe) |=> st.step == 3'h7;
    endproperty
    a_step_sat: assert property (p_step_sat) else $error("Step wrapped past max");
    property p_cnt_fixed;
        @(posedge sys_clk) disable iff (!resetn)
        (st.cnt == pat_pkg::CNT_MAX && !bus.wr) |=> st.cnt == pat_pkg::CNT_MAX;
    endproperty
    a_cnt_fixed: assert property (p_cnt_fixed) else $error("Stuck count moved");
    property p_irq_clears;
        @(posedge sys_clk) disable iff (!resetn)
        retrigger_irq |-> !st.rt[pat_pkg::RTON_BIT];
    endproperty
    a_irq_clears: assert property (p_irq_clears) else $error("Enable kept after irq");
    property p_sec_cnt_zero;
        @(posedge sys_clk) disable iff (!resetn)
        (st.sec_ctrl[1] == 1'b0) |=> st.sec_cnt == 8'h00;
    endproperty
    a_sec_cnt_zero: assert property (p_sec_cnt_zero) else $error("Width counter moved");
    property p_no_main;
        @(posedge sys_clk) disable iff (!resetn)
        !main_pulse_gen_on |=> !secondary_pulse;
    endproperty
    a_no_main: assert property (p_no_main) else $error("Secondary without main");
    property p_timer_idle;
        @(posedge sys_clk) disable iff (!resetn)
        (!st.tmc[pat_pkg::RUN_BIT] && !next_st.trig && !bus.wr) |=> st.tmr == $past(st.tmr);
    endproperty
    a_timer_idle: assert property (p_timer_idle) else $error("Timer moved while stopped");
endmodule

// [tb/pat_stage_model.sv]
// Purpose: Power stage and overvoltage source model
// Assumes: Main pulse free-runs while the bench enables it
// Notes:   Overvoltage pin moves only when the bench asks
`timescale 1ns/10ps
module pat_stage_model (
    // Clock
    input  wire logic sys_clk,
    // Bench control
    input  wire logic run,
    input  wire logic ov_level,
    // Towards the block
    output logic      main_pulse,
    output logic      overvoltage_event
);
    logic [4:0] ph = 5'h00;
    initial main_pulse = 1'b0;
    initial overvoltage_event = 1'b0;
    // Main pulse high 6 of every 20 cycles
    always @(posedge sys_clk) begin
        ph <= (ph == 5'h13) ? 5'h00 : ph + 5'h01;
        main_pulse <= run && (ph < 5'h06);
    end
    // Pin is asynchronous, so move it off the clock edge
    always @(ov_level) begin
        overvoltage_event <= #3 ov_level;
    end
endmodule

// [tb/tb_pat_ctrl.sv]
// Purpose: Self-checking bench for pat_ctrl
// Assumes: Register port per pat_pkg map
// Notes:   Expected values come from field codes only
`timescale 1ns/10ps
module tb_pat_ctrl;
    logic              sys_clk, resetn, gen_on, lock, stb, run, ov, main_p, ov_pin;
    logic              sec, rt_p, irq, tt;
    logic [1:0]        phase;
    logic [2:0]        cnt_v;
    logic [3:0]        step_v, rep_v;
    logic [7:0]        rdata, d, d0, tgt;
    pat_pkg::pat_bus_t bus;
    int                fails = 0, checked = 0, n, k;

    pat_ctrl uut (.sys_clk(sys_clk), .resetn(resetn), .bus(bus), .rdata(rdata),
        .main_pulse_gen_on(gen_on), .main_pulse(main_p), .overvoltage_event(ov_pin),
        .register_lock_flag(lock), .approach_phase(phase), .approach_step_strobe(stb),
        .secondary_pulse(sec), .retrigger_pulse(rt_p), .retrigger_irq(irq), .timer_trigger(tt),
        .trigger_count_val(cnt_v), .approach_step_val(step_v), .approach_repeat_val(rep_v),
        .approach_target(tgt));
    pat_stage_model stage (.sys_clk(sys_clk), .run(run), .ov_level(ov), .main_pulse(main_p),
        .overvoltage_event(ov_pin));

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle write; settle past the taking edge
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
        #1;
    endtask
    // One-cycle read; data taken while it stands in the next cycle
    task automatic rget(input logic [3:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        rget(a, d);
        chk(d, exp);
    endtask
    task automatic strobe(input int t);
        repeat (t) begin
            @(posedge sys_clk);
            stb <= 1'b1;
            @(posedge sys_clk);
            stb <= 1'b0;
        end
        #1;
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return tt;
            1: return rt_p;
            2: return irq;
            default: return sec;
        endcase
    endfunction
    // Cycles until an output goes high, bounded by lim
    task automatic wait_hi(input int s, input int lim, output int c);
        c = 0;
        do begin
            @(posedge sys_clk);
            #1;
            c++;
        end while (sig(s) !== 1'b1 && c <= lim);
    endtask
    // High cycles of an output over a window
    task automatic highs(input int s, input int cyc, output int h);
        h = 0;
        repeat (cyc) begin
            @(posedge sys_clk);
            #1;
            if (sig(s) === 1'b1) h++;
        end
    endtask
    task automatic end_of_test();
        $display("Counts: %0d checked, %0d failed", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Clock at 125 MHz
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Watchdog: tests need about 4500 cycles
    initial begin
        #200000;
        fails++;
        end_of_test();
    end
    // Main sequence
    initial begin
        resetn = 1'b0;
        bus = '0;
        {gen_on, lock, stb, run, ov, phase} = '0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        for (k = 0; k < 16; k++) rchk(4'(k), 8'h00);
        for (k = 0; k < 8; k++) begin
            wr(pat_pkg::ADDR_CNT_STEP, 8'(((k % 4) << 3) | k));
            wr(pat_pkg::ADDR_ADJUST, 8'(k << 4));
            chk(8'(cnt_v), 8'(k % 4 + 1));
            chk(8'(step_v), 8'(k + 1));
            chk(8'(rep_v), 8'(k + 1));
        end
        wr(pat_pkg::ADDR_PRELOAD1, 8'ha5);
        wr(pat_pkg::ADDR_PRELOAD2, 8'h5a);
        wr(pat_pkg::ADDR_PRELOAD3, 8'hc3);
        wr(pat_pkg::ADDR_RT_TIMES, 8'hff);
        wr(pat_pkg::ADDR_TMR_COUNT, 8'h55);
        rchk(pat_pkg::ADDR_PRELOAD1, 8'ha5);
        rchk(pat_pkg::ADDR_PRELOAD2, 8'h5a);
        rchk(pat_pkg::ADDR_PRELOAD3, 8'hc3);
        rchk(pat_pkg::ADDR_RT_TIMES, 8'h7f);
        rchk(pat_pkg::ADDR_TMR_COUNT, 8'h00);
        $display("Test registers done");
        // Software approach: increment and decrement with saturation, then stuck count codes and hold
        wr(pat_pkg::ADDR_ADJUST, 8'h7a);
        wr(pat_pkg::ADDR_CNT_STEP, 8'h0e);
        strobe(2);
        chk(8'(cnt_v), 8'h04);
        chk(8'(step_v), 8'h08);
        wr(pat_pkg::ADDR_ADJUST, 8'h7f);
        wr(pat_pkg::ADDR_CNT_STEP, 8'h11);
        strobe(2);
        chk(8'(cnt_v), 8'h01);
        chk(8'(step_v), 8'h01);
        wr(pat_pkg::ADDR_ADJUST, 8'h78);
        wr(pat_pkg::ADDR_CNT_STEP, 8'h00);
        strobe(1);
        chk(8'(cnt_v), 8'h01);
        wr(pat_pkg::ADDR_ADJUST, 8'h7c);
        wr(pat_pkg::ADDR_CNT_STEP, 8'h18);
        strobe(1);
        chk(8'(cnt_v), 8'h04);
        wr(pat_pkg::ADDR_ADJUST, 8'h75);
        wr(pat_pkg::ADDR_CNT_STEP, 8'h0b);
        strobe(1);
        chk(8'(cnt_v), 8'h02);
        chk(8'(step_v), 8'h04);
        // Hardware approach: direction follows the interval
        wr(pat_pkg::ADDR_MODE, 8'h01);
        wr(pat_pkg::ADDR_ADJUST, 8'h7a);
        wr(pat_pkg::ADDR_CNT_STEP, 8'h93);
        phase <= pat_pkg::PH_T2T3;
        strobe(1);
        chk(8'(cnt_v), 8'h02);
        chk(8'(step_v), 8'h03);
        phase <= pat_pkg::PH_T1T2;
        strobe(1);
        chk(8'(cnt_v), 8'h03);
        chk(8'(step_v), 8'h04);
        // Target moved by N+1 at each of the nine strobes so far
        chk(tgt, 8'h1f);
        lock <= 1'b1;
        wr(pat_pkg::ADDR_CNT_STEP, 8'h80);
        chk(8'(cnt_v), 8'h03);
        chk(8'(step_v), 8'h04);
        strobe(1);
        chk(tgt, 8'h1f);
        lock <= 1'b0;
        $display("Test approach done");
        // Trigger sources and edges in hardware mode
        wr(pat_pkg::ADDR_TMR_CTRL, 8'h10);
        chk(8'(tt), 8'h01);
        wr(pat_pkg::ADDR_CNT_STEP, 8'h13);
        wr(pat_pkg::ADDR_TMR_CTRL, 8'h00);
        rchk(pat_pkg::ADDR_TMR_CTRL, 8'h10);
        wr(pat_pkg::ADDR_MODE, 8'h00);
        wr(pat_pkg::ADDR_MODE, 8'h01);
        rchk(pat_pkg::ADDR_TMR_CTRL, 8'h00);
        rchk(pat_pkg::ADDR_TMR_COUNT, 8'ha5);
        ov <= 1'b1;
        wait_hi(0, 10, n);
        chk(8'(n <= 10), 8'h01);
        ov <= 1'b0;
        highs(0, 10, n);
        chk(8'(n), 8'h00);
        wr(pat_pkg::ADDR_TMR_CTRL, 8'h08);
        ov <= 1'b1;
        highs(0, 10, n);
        chk(8'(n), 8'h00);
        ov <= 1'b0;
        wait_hi(0, 10, n);
        chk(8'(n <= 10), 8'h01);
        wr(pat_pkg::ADDR_MODE, 8'h00);
        // Each prescale code: two ticks between reads two divider periods apart
        for (k = 0; k < 4; k++) begin
            wr(pat_pkg::ADDR_TMR_CTRL, 8'(8'h10 | k));
            rget(pat_pkg::ADDR_TMR_COUNT, d0);
            repeat ((256 << k) - 2) @(posedge sys_clk);
            rget(pat_pkg::ADDR_TMR_COUNT, d);
            chk(d - d0, 8'h02);
        end
        wr(pat_pkg::ADDR_TMR_CTRL, 8'h00);
        $display("Test timer done");
        // Re-trigger spacing, then self-clear with interrupt
        wr(pat_pkg::ADDR_RT_TIMES, 8'h03);
        wr(pat_pkg::ADDR_RT_PERIOD, 8'h81);
        wait_hi(1, 40, n);
        wait_hi(1, 40, n);
        chk(8'(n), 8'h10);
        wait_hi(2, 80, n);
        chk(8'(n <= 80), 8'h01);
        rchk(pat_pkg::ADDR_RT_PERIOD, 8'h01);
        $display("Test retrigger done");
        // Secondary pulse gating, copy and fixed modes
        run <= 1'b1;
        gen_on <= 1'b1;
        wr(pat_pkg::ADDR_SEC_CTRL, 8'h01);
        highs(3, 60, n);
        chk(8'(n), 8'h00);
        wr(pat_pkg::ADDR_SEC_CTRL, 8'h81);
        highs(3, 60, n);
        chk(8'(n), 8'h12);
        rchk(pat_pkg::ADDR_SEC_COUNT, 8'h00);
        gen_on <= 1'b0;
        repeat (20) @(posedge sys_clk);
        highs(3, 60, n);
        chk(8'(n), 8'h00);
        gen_on <= 1'b1;
        wr(pat_pkg::ADDR_SEC_CTRL, 8'h80);
        repeat (20) @(posedge sys_clk);
        highs(3, 60, n);
        chk(8'(n), 8'h00);
        // Fixed width 3: from the first high cycle, 60 cycles hold 2+3+3+1 high
        wr(pat_pkg::ADDR_SEC_WIDTH, 8'h03);
        wr(pat_pkg::ADDR_SEC_CTRL, 8'h82);
        wait_hi(3, 40, n);
        chk(8'(n <= 40), 8'h01);
        highs(3, 60, n);
        chk(8'(n), 8'h09);
        $display("Test secondary done");
        end_of_test();
    end
endmodule
